// ---- core/usreg_top.sv ----
/*
 Universal shift/storage register with common parallel pins, serial
 cascade ends, a capture FIFO of stage snapshots and a Wishbone slave.
 Assumes all device pins are asynchronous to clk_i; the device clock
 arrives as an ordinary pin and is sampled. Pin wires are resolved
 outside from the output enables.
*/
// Notes on behaviour
// - Eight storage stages, each on its pin
// - Low clear zeroes stages at next edge
// - State changes only on device rising edge
// - Mode selects choose the edge operation
// - Both selects high loads from pins
// - Shift right: serial in enters stage 0
// - Shift left: serial in enters last stage
// - Either enable high floats all pins
// - Operations continue while pins float
// - Load mode also floats the pins
// - End stages always on serial outputs
// - Driven pins show their stage values
`timescale 1ns/1ps
module usreg_top
   import usreg_pkg::*;
#(
   parameter int STAGES = STAGE_COUNT,
   parameter int DEPTH = FIFO_DEPTH
)
(
   // System
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Device control pins
   input wire logic clock_pulse_i,
   input wire logic sync_clear_n_i,
   input wire logic mode_select_low_i,
   input wire logic mode_select_high_i,
   input wire logic output_enable_a_n_i,
   input wire logic output_enable_b_n_i,
   // Serial cascade
   input wire logic right_shift_serial_in_i,
   input wire logic left_shift_serial_in_i,
   output logic first_stage_serial_out_o,
   output logic last_stage_serial_out_o,
   // Parallel two-way pins
   input wire logic [STAGES-1:0] parallel_bidir_pins_i,
   output logic [STAGES-1:0] parallel_bidir_pins_o,
   output logic [STAGES-1:0] parallel_bidir_pins_oe_o,
   // Capture path
   output logic capture_ready_o
);

   localparam int SW = STAGES + 8;
   localparam int LW = $clog2(DEPTH) + 1;

   if (STAGES < 2 || STAGES > 8 || LW > 4)
   begin : g_bad_size
      $error("usreg_top: STAGES must be 2..8 and DEPTH at most 8");
   end

   // ==========================================================
   // State
   typedef struct packed {
      logic [STAGES-1:0] q;
      logic [STAGES-1:0] oe;
      logic pulse_prev;
      logic capture_en;
      logic overflow;
      logic push;
      logic ready;
      usreg_bus_t bus;
      logic ack;
      logic [31:0] dat;
   } usreg_st_t;

   usreg_st_t st;
   usreg_st_t next_st;

   // ==========================================================
   // Pin synchronisers
   logic [SW-1:0] sync_out;
   logic sy_pulse;
   logic sy_clear_n;
   logic sy_high;
   logic sy_low;
   logic sy_rsi;
   logic sy_lsi;
   logic sy_oea_n;
   logic sy_oeb_n;
   logic [STAGES-1:0] sy_pins;

   usreg_sync #(
      .WIDTH(SW),
      .RESET_VALUE({SYNC_CTL_RESET, {STAGES{1'b0}}})
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .raw_i({clock_pulse_i, sync_clear_n_i, mode_select_high_i,
              mode_select_low_i, right_shift_serial_in_i,
              left_shift_serial_in_i, output_enable_a_n_i,
              output_enable_b_n_i, parallel_bidir_pins_i}),
      .stable_o(sync_out)
   );

   // Unpack the filtered levels; all share the same delay
   assign {sy_pulse, sy_clear_n, sy_high, sy_low, sy_rsi, sy_lsi,
           sy_oea_n, sy_oeb_n, sy_pins} = sync_out;

   // ==========================================================
   // Capture FIFO
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [STAGES-1:0] fifo_out_data;
   logic [LW-1:0] fifo_level;

   usreg_fifo #(
      .WIDTH(STAGES),
      .DEPTH(DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_valid_i(st.push),
      .in_ready_o(fifo_in_ready),
      .in_data_i(st.q),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_out_ready),
      .out_data_o(fifo_out_data),
      .level_o(fifo_level)
   );

   // ==========================================================
   // Shift neighbours per stage
   logic [STAGES-1:0] shr_val;
   logic [STAGES-1:0] shl_val;

   for (genvar i = 0; i < STAGES; i++)
   begin : g_stage
      if (i == 0)
      begin : g_first
         assign shr_val[i] = sy_rsi;
      end
      else
      begin : g_inner_r
         assign shr_val[i] = st.q[i-1];
      end
      if (i == STAGES - 1)
      begin : g_last
         assign shl_val[i] = sy_lsi;
      end
      else
      begin : g_inner_l
         assign shl_val[i] = st.q[i+1];
      end
   end

   // ==========================================================
   // Decode helpers
   usreg_mode_t mode;
   logic pulse_rise;
   logic bus_req;
   logic bus_wr;
   logic clr_ovf;
   logic [31:0] status_word;

   assign mode = usreg_mode_of(sy_high, sy_low);
   assign pulse_rise = sy_pulse && !st.pulse_prev;
   assign bus_req = wb_cyc_i && wb_stb_i;
   assign bus_wr = (st.bus == BUS_ACK) && bus_req && wb_we_i && wb_sel_i[0];
   assign clr_ovf = bus_wr && (wb_adr_i == OFS_CLEAR) && wb_dat_i[CLR_OVF_BIT];
   // Pop only a word that the read actually returned
   assign fifo_out_ready = (st.bus == BUS_ACK) && bus_req && !wb_we_i
                           && (wb_adr_i == OFS_DATA) && st.dat[ST_AVAIL_BIT];

   // Status word assembly
   always_comb
   begin
      status_word = '0;
      status_word[ST_STAGE_LSB +: STAGES] = st.q;
      status_word[ST_AVAIL_BIT] = fifo_out_valid;
      status_word[ST_OVF_BIT] = st.overflow;
      status_word[ST_READY_BIT] = fifo_in_ready;
      status_word[ST_LEVEL_LSB +: LW] = fifo_level;
   end

   // ==========================================================
   // Next state: device edge, pin drive, bus slave
   always_comb
   begin
      next_st = st;
      next_st.pulse_prev = sy_pulse;
      next_st.push = 1'b0;
      next_st.ack = 1'b0;
      // Stages move only on a device rising edge
      if (pulse_rise)
      begin
         next_st.push = st.capture_en;
         if (!sy_clear_n)
         begin
            next_st.q = '0;
         end
         else
         begin
            case (mode)
               MODE_LOAD: next_st.q = sy_pins;
               MODE_SHR: next_st.q = shr_val;
               MODE_SHL: next_st.q = shl_val;
               MODE_HOLD: next_st.q = st.q;
               default: next_st.q = st.q;
            endcase
         end
      end
      // Drive only with both enables low and not loading
      next_st.oe = {STAGES{!sy_oea_n && !sy_oeb_n && (mode != MODE_LOAD)}};
      // A snapshot that finds the FIFO full is lost; set beats clear
      next_st.overflow = (st.overflow && !clr_ovf) || (st.push && !fifo_in_ready);
      next_st.ready = fifo_in_ready;
      // Bus: answer one cycle after the request, effects at the ack edge
      case (st.bus)
         BUS_IDLE:
         begin
            if (bus_req)
            begin
               next_st.bus = BUS_ACK;
               next_st.ack = 1'b1;
               next_st.dat = '0;
               if (!wb_we_i)
               begin
                  case (wb_adr_i)
                     OFS_CTRL: next_st.dat[CTRL_CAPTURE_BIT] = st.capture_en;
                     OFS_STATUS: next_st.dat = status_word;
                     OFS_DATA:
                     begin
                        next_st.dat[STAGES-1:0] = fifo_out_data;
                        next_st.dat[ST_AVAIL_BIT] = fifo_out_valid;
                     end
                     default: next_st.dat = '0;
                  endcase
               end
            end
         end
         BUS_ACK:
         begin
            next_st.bus = BUS_IDLE;
            if (bus_wr && (wb_adr_i == OFS_CTRL))
            begin
               next_st.capture_en = wb_dat_i[CTRL_CAPTURE_BIT];
            end
         end
         default: next_st.bus = BUS_IDLE;
      endcase
   end

   // Register the state
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st <= '0;
         st.capture_en <= CTRL_RESET;
      end
      else
      begin
         st <= next_st;
      end
   end

   // ==========================================================
   // Outputs straight from flip-flops
   assign parallel_bidir_pins_o = st.q;
   assign parallel_bidir_pins_oe_o = st.oe;
   assign first_stage_serial_out_o = st.q[0];
   assign last_stage_serial_out_o = st.q[STAGES-1];
   assign wb_dat_o = st.dat;
   assign wb_ack_o = st.ack;
   assign capture_ready_o = st.ready;

   // ==========================================================
   // Checks
   logic [STAGES-2:0] q_low;
   logic [STAGES-2:0] q_high;
   logic drive_ok;

   assign q_low = st.q[STAGES-2:0];
   assign q_high = st.q[STAGES-1:1];
   assign drive_ok = !sy_oea_n && !sy_oeb_n && (mode != MODE_LOAD);

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_clear_zero: assert property (pulse_rise && !sy_clear_n |=> st.q == '0)
      else $error("clear did not zero the stages");
   chk_edge_only: assert property (!pulse_rise |=> $stable(st.q))
      else $error("stages changed without a device edge");
   chk_load_pins: assert property (pulse_rise && sy_clear_n && mode == MODE_LOAD
      |=> st.q == $past(sy_pins))
      else $error("parallel load took wrong data");
   chk_shift_right: assert property (pulse_rise && sy_clear_n && mode == MODE_SHR
      |=> first_stage_serial_out_o == $past(sy_rsi) && q_high == $past(q_low))
      else $error("right shift wrong");
   chk_shift_left: assert property (pulse_rise && sy_clear_n && mode == MODE_SHL
      |=> last_stage_serial_out_o == $past(sy_lsi) && q_low == $past(q_high))
      else $error("left shift wrong");
   chk_hold_keep: assert property (pulse_rise && sy_clear_n && mode == MODE_HOLD
      |=> $stable(st.q))
      else $error("hold mode changed the stages");
   chk_pins_float: assert property (!drive_ok |=> parallel_bidir_pins_oe_o == '0)
      else $error("pins driven while disabled or loading");
   chk_pins_drive: assert property (drive_ok ##1 drive_ok
      |-> parallel_bidir_pins_oe_o == '1 && parallel_bidir_pins_o == st.q)
      else $error("pins not driven with stage values");
   chk_run_floating: assert property (pulse_rise && (sy_oea_n || sy_oeb_n) && !sy_clear_n
      |=> parallel_bidir_pins_oe_o == '0 ##1 st.q == '0)
      else $error("operation stalled while pins float");
   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");

   cov_load: cover property (pulse_rise && sy_clear_n && mode == MODE_LOAD);
   cov_shift_r: cover property (pulse_rise && sy_clear_n && mode == MODE_SHR);
   cov_shift_l: cover property (pulse_rise && sy_clear_n && mode == MODE_SHL);
   cov_overflow: cover property (st.push && !fifo_in_ready);

endmodule

// ---- core/usreg_pkg.sv ----
/*
 Shared constants and types for the universal shift/storage register:
 register offsets, field positions, reset values and the mode encoding.
 Assumes a 32-bit classic Wishbone slave with byte addresses.
*/
package usreg_pkg;

   // ==========================================================
   // Sizes
   localparam int STAGE_COUNT = 8;
   localparam int FIFO_DEPTH = 8;
   localparam int ADR_W = 8;

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_DATA = 8'h08;
   localparam logic [7:0] OFS_CLEAR = 8'h0c;

   // ==========================================================
   // Field positions
   localparam int CTRL_CAPTURE_BIT = 0;
   localparam int ST_STAGE_LSB = 0;
   localparam int ST_AVAIL_BIT = 8;
   localparam int ST_OVF_BIT = 9;
   localparam int ST_READY_BIT = 10;
   localparam int ST_LEVEL_LSB = 12;
   localparam int CLR_OVF_BIT = 0;

   // ==========================================================
   // Reset values
   localparam logic CTRL_RESET = 1'b0;
   // Pulse, clear_n, high, low, right in, left in, enable a_n, enable b_n
   localparam logic [7:0] SYNC_CTL_RESET = 8'h43;

   // ==========================================================
   // Operation selected by {high, low} mode select
   typedef enum logic [1:0] {
      MODE_HOLD = 2'b00,
      MODE_SHR = 2'b01,
      MODE_SHL = 2'b10,
      MODE_LOAD = 2'b11
   } usreg_mode_t;

   // Bus answer machine
   typedef enum logic {
      BUS_IDLE = 1'b0,
      BUS_ACK = 1'b1
   } usreg_bus_t;

   // Decode the two mode select pins
   function automatic usreg_mode_t usreg_mode_of(input logic high, input logic low);
      return usreg_mode_t'({high, low});
   endfunction

endpackage

// ---- core/usreg_sync.sv ----
/*
 Three-stage input synchroniser with agreement filter.
 Assumes asynchronous inputs; a bit's stable value follows only once the
 second and third stages agree.
*/
`timescale 1ns/1ps
module usreg_sync
#(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
   // System
   input wire logic clk_i,
   input wire logic rst_i,
   // Raw and filtered levels
   input wire logic [WIDTH-1:0] raw_i,
   output logic [WIDTH-1:0] stable_o
);

   // ==========================================================
   // State
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] stable;
   } usreg_sync_st_t;

   usreg_sync_st_t st;
   usreg_sync_st_t next_st;

   if (WIDTH < 1)
   begin : g_bad_width
      $error("usreg_sync: WIDTH must be at least 1");
   end

   // Shift chain; first stage feeds only the second
   always_comb
   begin
      next_st = st;
      next_st.s1 = raw_i;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      for (int i = 0; i < WIDTH; i++)
      begin
         if (st.s2[i] == st.s3[i])
         begin
            next_st.stable[i] = st.s3[i];
         end
      end
   end

   // Register the state
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st <= '{RESET_VALUE, RESET_VALUE, RESET_VALUE, RESET_VALUE};
      end
      else
      begin
         st <= next_st;
      end
   end

   assign stable_o = st.stable;

endmodule

// ---- core/usreg_fifo.sv ----
/*
 Synchronous FIFO with valid/ready on both sides.
 Assumes one clock; DEPTH is a power of two.
*/
`timescale 1ns/1ps
module usreg_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
)
(
   // System
   input wire logic clk_i,
   input wire logic rst_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o,
   output logic [$clog2(DEPTH):0] level_o
);

   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

   // ==========================================================
   // State
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] count;
   } usreg_fifo_st_t;

   usreg_fifo_st_t st;
   usreg_fifo_st_t next_st;
   logic push;
   logic pop;

   if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
   begin : g_bad_size
      $error("usreg_fifo: DEPTH must be a power of two, at least 2");
   end

   // Honest full and empty
   assign in_ready_o = (st.count != FULL);
   assign out_valid_o = (st.count != '0);
   assign out_data_o = st.mem[st.rd];
   assign level_o = st.count;
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // Pointer and count update
   always_comb
   begin
      next_st = st;
      if (push)
      begin
         next_st.mem[st.wr] = in_data_i;
         next_st.wr = st.wr + 1'b1;
      end
      if (pop)
      begin
         next_st.rd = st.rd + 1'b1;
      end
      case ({push, pop})
         2'b10: next_st.count = st.count + 1'b1;
         2'b01: next_st.count = st.count - 1'b1;
         default: next_st.count = st.count;
      endcase
   end

   // Register the state
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

endmodule

// ---- sim/usreg_pins_model.sv ----
/*
 Far-side model: bus logic that shares the parallel pins with the register.
 Assumes the bench tells it when to drive parallel load data.
*/
`timescale 1ns/1ps
module usreg_pins_model
(
   // System
   input wire logic clk_i,
   // Device side
   input wire logic [7:0] dev_val_i,
   input wire logic [7:0] dev_oe_i,
   // Bench side
   input wire logic drive_i,
   input wire logic [7:0] drive_val_i,
   // Resolved wire
   output logic [7:0] wire_o
);
   logic [7:0] last = 8'h00;
   // ==========================================================
   // Resolve each wire; a floating bit shows the inverse of its last level
   always_comb
   begin
      for (int i = 0; i < 8; i++)
         wire_o[i] = dev_oe_i[i] ? dev_val_i[i] : (drive_i ? drive_val_i[i] : ~last[i]);
   end
   // Remember the last level so a released wire never looks stable
   always_ff @(posedge clk_i)
   begin
      last <= wire_o;
   end
endmodule

// ---- sim/universal_shift_storage_register_test.sv ----
/*
 Self-checking bench: Wishbone reads and device pin sequences with expected
 stage values. Assumes the design package and the pin model are compiled first.
*/
`timescale 1ns/1ps
module universal_shift_storage_register_test;
   import usreg_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic wb_ack_o, first_o, last_o, cap_rdy;
   logic clock_pulse_i = 1'b0, clear_n = 1'b1, mlow = 1'b0, mhigh = 1'b0;
   logic ena_n = 1'b0, enb_n = 1'b0, rsi = 1'b0, lsi = 1'b0, drive = 1'b0;
   logic [7:0] dval = 8'h00, pins_w, pins_o, pins_oe;
   int fails = 0;
   int total_checks = 0;
   // ==========================================================
   // Design and far-side model
   usreg_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .clock_pulse_i(clock_pulse_i),
      .sync_clear_n_i(clear_n), .mode_select_low_i(mlow), .mode_select_high_i(mhigh),
      .output_enable_a_n_i(ena_n), .output_enable_b_n_i(enb_n),
      .right_shift_serial_in_i(rsi), .left_shift_serial_in_i(lsi),
      .first_stage_serial_out_o(first_o), .last_stage_serial_out_o(last_o),
      .parallel_bidir_pins_i(pins_w), .parallel_bidir_pins_o(pins_o),
      .parallel_bidir_pins_oe_o(pins_oe), .capture_ready_o(cap_rdy));
   usreg_pins_model far_side (.clk_i(clk_i), .dev_val_i(pins_o), .dev_oe_i(pins_oe),
      .drive_i(drive), .drive_val_i(dval), .wire_o(pins_w));
   // Clock
   initial
   begin
      forever #2.5 clk_i = ~clk_i;
   end
   // ==========================================================
   // Tasks
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e)
      begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // One classic Wishbone cycle, entered just after a rising edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rdat);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= wd;
      wb_sel_i <= 4'hf;
      // Wait for the answer; only the watchdog ends a hung wait
      do
      begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      rdat = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   // Apply device pins, then one pulse if asked, with synchroniser margins
   task automatic op(input logic [1:0] m, input logic cn, input logic r, input logic l,
                     input logic p);
      mhigh <= m[1];
      mlow <= m[0];
      clear_n <= cn;
      rsi <= r;
      lsi <= l;
      repeat (5) @(posedge clk_i);
      clock_pulse_i <= p;
      repeat (4) @(posedge clk_i);
      clock_pulse_i <= 1'b0;
      repeat (8) @(posedge clk_i);
   endtask
   // Stages through the status register and the serial ends
   task automatic chk_q(input logic [7:0] e);
      logic [31:0] d;
      bus(1'b0, OFS_STATUS, 32'h0, d);
      chk(d[7:0], e);
      chk({first_o, last_o}, {e[0], e[7]});
   endtask
   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Watchdog
   initial
   begin
      #50000;
      fails++;
      $display("wrong value at %0t: watchdog expired", $time);
      end_of_test();
   end
   // ==========================================================
   // Tests
   initial
   begin
      logic [31:0] d;
      logic [7:0] q;
      logic [7:0] s;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      bus(1'b0, OFS_STATUS, 32'h0, d);
      chk(d[15:0], 16'h0400);
      bus(1'b0, 8'h10, 32'h0, d);
      chk(d, 32'h0);
      chk(pins_oe, 8'hff);
      $display("test reset done");
      // Parallel load, pins released
      drive <= 1'b1;
      dval <= 8'ha5;
      // Let the pins settle to the driven data before the load edge
      op(2'b11, 1'b1, 1'b0, 1'b0, 1'b0);
      op(2'b11, 1'b1, 1'b0, 1'b0, 1'b1);
      chk(pins_oe, 8'h00);
      drive <= 1'b0;
      q = 8'ha5;
      chk_q(q);
      op(2'b00, 1'b1, 1'b1, 1'b1, 1'b1);
      chk_q(q);
      chk({pins_oe, pins_o}, {8'hff, q});
      op(2'b01, 1'b1, 1'b0, 1'b1, 1'b1);
      q = {q[6:0], 1'b0};
      chk_q(q);
      op(2'b10, 1'b1, 1'b0, 1'b1, 1'b1);
      q = {1'b1, q[7:1]};
      chk_q(q);
      // Cascade ring: last serial output feeds the right-shift input
      op(2'b01, 1'b1, last_o, 1'b0, 1'b1);
      q = {q[6:0], q[7]};
      chk_q(q);
      $display("test modes done");
      // Shifting with pins floated
      ena_n <= 1'b1;
      op(2'b01, 1'b1, 1'b1, 1'b0, 1'b1);
      q = {q[6:0], 1'b1};
      chk(pins_oe, 8'h00);
      chk_q(q);
      ena_n <= 1'b0;
      enb_n <= 1'b1;
      op(2'b10, 1'b1, 1'b0, 1'b1, 1'b0);
      chk(pins_oe, 8'h00);
      chk_q(q);
      op(2'b11, 1'b0, 1'b1, 1'b1, 1'b0);
      chk_q(q);
      op(2'b11, 1'b0, 1'b1, 1'b1, 1'b1);
      q = 8'h00;
      chk_q(q);
      enb_n <= 1'b0;
      $display("test enables and clear done");
      // Capture FIFO: nine snapshots into eight places, then drain
      bus(1'b1, OFS_CTRL, 32'h1, d);
      repeat (9) op(2'b01, 1'b1, 1'b1, 1'b0, 1'b1);
      chk(cap_rdy, 1'b0);
      bus(1'b0, OFS_STATUS, 32'h0, d);
      chk(d[15:0], 16'h83ff);
      s = 8'h00;
      for (int k = 0; k < 8; k++)
      begin
         s = {s[6:0], 1'b1};
         bus(1'b0, OFS_DATA, 32'h0, d);
         chk(d[8:0], {1'b1, s});
      end
      bus(1'b0, OFS_DATA, 32'h0, d);
      chk(d[8], 1'b0);
      bus(1'b1, OFS_CLEAR, 32'h1, d);
      bus(1'b1, OFS_CTRL, 32'h0, d);
      bus(1'b0, OFS_STATUS, 32'h0, d);
      chk(d[15:0], 16'h04ff);
      chk(cap_rdy, 1'b1);
      $display("test capture done");
      end_of_test();
   end
endmodule
